// ==== pcr_regs.vh ====
// register offsets, field positions, reset values and frame counts
`ifndef PCR_REGS_VH
`define PCR_REGS_VH
`define PCR_ADDR_W          6
`define PCR_DATA_W          24
`define PCR_FRAME_BITS      6'd32
`define PCR_ADDR_LAST       6'd6
`define PCR_DATA_FIRST      6'd7
`define PCR_WORD_LAST       6'd31
`define PCR_OFS_ENABLE      6'h01
`define PCR_OFS_SDO_FORCE   6'h02
`define PCR_OFS_REF_PATH    6'h03
`define PCR_OFS_PRESCALER   6'h04
`define PCR_OFS_PD_CTRL     6'h05
`define PCR_OFS_PD_DELAY    6'h06
`define PCR_OFS_PUMP_CUR    6'h07
`define PCR_RST_ENABLE      16'hfe9b
`define PCR_RST_SDO_FORCE   2'h3
`define PCR_RST_REF_PATH    17'h08001
`define PCR_RST_PRESCALER   1'h0
`define PCR_RST_PD_CTRL     3'h6
`define PCR_RST_PD_DELAY    3'h2
`define PCR_RST_PUMP_CUR    10'h210
`define PCR_EN_OSC_BUF      0
`define PCR_EN_BIAS         1
`define PCR_EN_REF_DIV      2
`define PCR_EN_XREF_DIG     3
`define PCR_EN_DIVREF_DIG   4
`define PCR_EN_SQR_DIG      5
`define PCR_EN_SIN_DIG      6
`define PCR_EN_SQ_BUF       7
`define PCR_EN_SIN_BUF      8
`define PCR_EN_OSC_DIG      9
`define PCR_EN_PRESC        10
`define PCR_EN_LKD_LOGIC    11
`define PCR_EN_PUMP         12
`define PCR_EN_MOD_RUN      13
`define PCR_EN_LKD_RUN      14
`define PCR_EN_SLIP         15
`define PCR_SDO_FORCE_VAL   0
`define PCR_SDO_FORCE_EN    1
`define PCR_REF_RATIO_HI    13
`define PCR_REF_DIV_SEL     14
`define PCR_REF_AUTO        15
`define PCR_REF_SIN_SEL     16
`define PCR_REF_RATIO_ONE   14'h0001
`define PCR_PD_INVERT       0
`define PCR_PD_UP_PASS      1
`define PCR_PD_DN_PASS      2
`define PCR_CUR_UP_HI       4
`define PCR_CUR_DN_LO       5
`define PCR_CUR_DN_HI       9
`endif

// ==== pcr_serial_port.v ====
// serial frame receiver and readback shifter
`timescale 1ns/10ps
`include "pcr_regs.vh"
module pcr_serial_port (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   sclk,
    input  wire                   serial_select,
    input  wire                   serial_in,
    input  wire [`PCR_DATA_W-1:0] rd_data,
    output reg  [`PCR_ADDR_W-1:0] addr_reg,
    output reg  [`PCR_DATA_W-1:0] wr_data_reg,
    output reg                    wr_pulse_reg,
    output reg                    read_drive_reg,
    output reg                    sdo_reg
);
    reg                   sclk_reg;
    reg [5:0]             cnt_reg;
    reg                   rd_mode_reg;
    reg [`PCR_DATA_W-1:0] shift_reg;
    reg [`PCR_DATA_W-1:0] out_reg;
    wire rise = sclk & ~sclk_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_reg       <= 1'b0;
            cnt_reg        <= 6'd0;
            rd_mode_reg    <= 1'b0;
            shift_reg      <= 24'h000000;
            out_reg        <= 24'h000000;
            addr_reg       <= 6'h00;
            wr_data_reg    <= 24'h000000;
            wr_pulse_reg   <= 1'b0;
            read_drive_reg <= 1'b0;
            sdo_reg        <= 1'b0;
        end else begin
            sclk_reg     <= sclk;
            wr_pulse_reg <= 1'b0;
            if (!serial_select) begin
                cnt_reg        <= 6'd0;
                rd_mode_reg    <= 1'b0;
                read_drive_reg <= 1'b0;
            end else if (rise && cnt_reg != `PCR_FRAME_BITS) begin
                cnt_reg   <= cnt_reg + 6'd1;
                shift_reg <= {shift_reg[`PCR_DATA_W-2:0], serial_in};
                if (cnt_reg == 6'd0)
                    rd_mode_reg <= serial_in; // [RULE24]
                if (cnt_reg == `PCR_ADDR_LAST)
                    addr_reg <= {shift_reg[4:0], serial_in};
                if (rd_mode_reg && cnt_reg == `PCR_DATA_FIRST) begin
                    out_reg        <= {rd_data[`PCR_DATA_W-2:0], 1'b0};
                    sdo_reg        <= rd_data[`PCR_DATA_W-1];
                    read_drive_reg <= 1'b1;
                end else if (rd_mode_reg && cnt_reg > `PCR_DATA_FIRST) begin
                    out_reg <= {out_reg[`PCR_DATA_W-2:0], 1'b0};
                    sdo_reg <= out_reg[`PCR_DATA_W-1];
                end
                if (!rd_mode_reg && cnt_reg == `PCR_WORD_LAST) begin
                    wr_data_reg  <= shift_reg; // [RULE23]
                    wr_pulse_reg <= 1'b1;
                end
            end
        end
    end
endmodule // pcr_serial_port

// ==== pcr_top.v ====
// synthesizer core configuration register bank, offsets 0x01 to 0x07
// Function
// [RULE1] bias bit clear disables whole loop
// [RULE2] bit 2 runs or resets reference divider
// [RULE3] bit 9 picks modulator clock source
// [RULE4] bit 12 clear tri-states charge pump
// [RULE5] bit 13 low holds modulator reset
// [RULE6] bit 14 low holds lock detect reset
// [RULE7] slip prevention needs bit 15 and arm
// [RULE8] bit 11 gates lock logic and outputs
// [RULE9] buffer enables qualified by sine select
// [RULE10] bit 16 selects sine reference buffer
// [RULE11] force enable drives force value out
// [RULE12] ratio field divides crystal, never zero
// [RULE13] bit 14 routes through or bypasses divider
// [RULE14] auto mode bypasses divider at ratio one
// [RULE15] prescaler bit extends low time
// [RULE16] phase detector bit 0 inverts polarity
// [RULE17] bits 1,2 mask up and down outputs
// [RULE18] three bit delay set point, reset two
// [RULE19] two five bit pump current settings
// [RULE20] bit 3 gates crystal reference to logic
// [RULE21] bits 4-6 gate three clocks to logic
// [RULE22] oscillator buffer and prescaler bias enables
// [RULE23] write frame: six address, 24 data bits
// [RULE24] first sampled bit picks read or write
// [RULE25] reset restores defaults, unused bits zero
`timescale 1ns/10ps
`include "pcr_regs.vh"
module pcr_top (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire        sclk,
    input  wire        serial_select,
    input  wire        serial_in,
    input  wire        slip_arm,
    input  wire        pd_up_raw,
    input  wire        pd_dn_raw,
    input  wire        pd_lock_raw,
    output reg         lock_or_readback_pin_out,
    output reg         lock_or_readback_pin_oe,
    output reg         osc_buffer_on,
    output reg         loop_bias_on,
    output reg         ref_divider_run,
    output reg         ref_divider_used,
    output reg  [13:0] ref_divide_ratio,
    output reg         xref_to_digital_on,
    output reg         div_ref_to_digital_on,
    output reg         square_clk_to_digital_on,
    output reg         sine_clk_to_digital_on,
    output reg         square_ref_buffer_on,
    output reg         sine_ref_buffer_on,
    output reg         mod_clk_from_osc,
    output reg         prescaler_bias_on,
    output reg         lock_logic_on,
    output reg         pump_output_on,
    output reg         modulator_run,
    output reg         lock_detect_run,
    output reg         slip_prevention_on,
    output reg         prescaler_long_low,
    output reg         pd_invert,
    output reg         pump_up,
    output reg         pump_dn,
    output reg         lock_detect_out,
    output reg  [2:0]  pd_delay,
    output reg  [4:0]  pump_up_current,
    output reg  [4:0]  pump_down_current
);
    reg         rst_meta_reg;
    reg         rst_sync_reg;
    wire        rst_n;

    reg  [15:0] enable_reg;
    reg  [1:0]  sdo_force_reg;
    reg  [16:0] ref_path_reg;
    reg         prescaler_reg;
    reg  [2:0]  pd_ctrl_reg;
    reg  [2:0]  pd_delay_reg;
    reg  [9:0]  pump_cur_reg;

    wire [5:0]  addr;
    wire [23:0] wr_data;
    wire        wr_pulse;
    wire        read_drive;
    wire        sdo_bit;
    reg  [23:0] rd_data;

    wire        bias;
    wire        sin_sel;
    wire [13:0] ratio;
    wire        div_path_next;
    wire        up_next;
    wire        dn_next;

    // reset release through two flops
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    pcr_serial_port u_port (
        .clk            (core_clk),
        .rst_n          (rst_n),
        .sclk           (sclk),
        .serial_select  (serial_select),
        .serial_in      (serial_in),
        .rd_data        (rd_data),
        .addr_reg       (addr),
        .wr_data_reg    (wr_data),
        .wr_pulse_reg   (wr_pulse),
        .read_drive_reg (read_drive),
        .sdo_reg        (sdo_bit)
    );

    // register writes
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg    <= `PCR_RST_ENABLE; // [RULE25]
            sdo_force_reg <= `PCR_RST_SDO_FORCE;
            ref_path_reg  <= `PCR_RST_REF_PATH;
            prescaler_reg <= `PCR_RST_PRESCALER;
            pd_ctrl_reg   <= `PCR_RST_PD_CTRL;
            pd_delay_reg  <= `PCR_RST_PD_DELAY; // [RULE18]
            pump_cur_reg  <= `PCR_RST_PUMP_CUR;
        end else if (wr_pulse) begin
            case (addr)
                `PCR_OFS_ENABLE: begin
                    enable_reg <= wr_data[15:0];
                end
                `PCR_OFS_SDO_FORCE: begin
                    sdo_force_reg <= wr_data[1:0];
                end
                `PCR_OFS_REF_PATH: begin
                    ref_path_reg <= wr_data[16:0]; // [RULE12]
                end
                `PCR_OFS_PRESCALER: begin
                    prescaler_reg <= wr_data[0];
                end
                `PCR_OFS_PD_CTRL: begin
                    pd_ctrl_reg <= wr_data[2:0];
                end
                `PCR_OFS_PD_DELAY: begin
                    pd_delay_reg <= wr_data[2:0];
                end
                `PCR_OFS_PUMP_CUR: begin
                    pump_cur_reg <= wr_data[9:0]; // [RULE19]
                end
                default: begin
                    pump_cur_reg <= pump_cur_reg;
                end
            endcase
        end
    end

    // readback, unused bits and unmapped offsets read zero
    always @* begin
        rd_data = 24'h000000; // [RULE25]
        case (addr)
            `PCR_OFS_ENABLE: begin
                rd_data[15:0] = enable_reg;
            end
            `PCR_OFS_SDO_FORCE: begin
                rd_data[1:0] = sdo_force_reg;
            end
            `PCR_OFS_REF_PATH: begin
                rd_data[16:0] = ref_path_reg;
            end
            `PCR_OFS_PRESCALER: begin
                rd_data[0] = prescaler_reg;
            end
            `PCR_OFS_PD_CTRL: begin
                rd_data[2:0] = pd_ctrl_reg;
            end
            `PCR_OFS_PD_DELAY: begin
                rd_data[2:0] = pd_delay_reg;
            end
            `PCR_OFS_PUMP_CUR: begin
                rd_data[9:0] = pump_cur_reg;
            end
            default: begin
                rd_data = 24'h000000;
            end
        endcase
    end

    // derived controls
    assign bias    = enable_reg[`PCR_EN_BIAS];
    assign sin_sel = ref_path_reg[`PCR_REF_SIN_SEL];
    assign ratio   = ref_path_reg[`PCR_REF_RATIO_HI:0];
    assign div_path_next = enable_reg[`PCR_EN_REF_DIV] &
                           (ref_path_reg[`PCR_REF_AUTO] ? (ratio != `PCR_REF_RATIO_ONE) // [RULE14]
                                                        : ref_path_reg[`PCR_REF_DIV_SEL]); // [RULE13]
    assign up_next = pd_ctrl_reg[`PCR_PD_INVERT] ? pd_dn_raw : pd_up_raw; // [RULE16]
    assign dn_next = pd_ctrl_reg[`PCR_PD_INVERT] ? pd_up_raw : pd_dn_raw;

    // registered outputs
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_or_readback_pin_out <= 1'b0;
            lock_or_readback_pin_oe  <= 1'b0;
            osc_buffer_on            <= 1'b0;
            loop_bias_on             <= 1'b0;
            ref_divider_run          <= 1'b0;
            ref_divider_used         <= 1'b0;
            ref_divide_ratio         <= 14'h0000;
            xref_to_digital_on       <= 1'b0;
            div_ref_to_digital_on    <= 1'b0;
            square_clk_to_digital_on <= 1'b0;
            sine_clk_to_digital_on   <= 1'b0;
            square_ref_buffer_on     <= 1'b0;
            sine_ref_buffer_on       <= 1'b0;
            mod_clk_from_osc         <= 1'b0;
            prescaler_bias_on        <= 1'b0;
            lock_logic_on            <= 1'b0;
            pump_output_on           <= 1'b0;
            modulator_run            <= 1'b0;
            lock_detect_run          <= 1'b0;
            slip_prevention_on       <= 1'b0;
            prescaler_long_low       <= 1'b0;
            pd_invert                <= 1'b0;
            pump_up                  <= 1'b0;
            pump_dn                  <= 1'b0;
            lock_detect_out          <= 1'b0;
            pd_delay                 <= 3'h0;
            pump_up_current          <= 5'h00;
            pump_down_current        <= 5'h00;
        end else begin
            if (sdo_force_reg[`PCR_SDO_FORCE_EN]) begin
                lock_or_readback_pin_out <= sdo_force_reg[`PCR_SDO_FORCE_VAL]; // [RULE11]
                lock_or_readback_pin_oe  <= 1'b1;
            end else begin
                lock_or_readback_pin_out <= sdo_bit;
                lock_or_readback_pin_oe  <= read_drive;
            end
            osc_buffer_on            <= enable_reg[`PCR_EN_OSC_BUF]; // [RULE22]
            prescaler_bias_on        <= enable_reg[`PCR_EN_PRESC] & bias; // [RULE22]
            loop_bias_on             <= bias; // [RULE1]
            ref_divider_run          <= enable_reg[`PCR_EN_REF_DIV] & bias; // [RULE2]
            ref_divider_used         <= div_path_next; // [RULE2]
            ref_divide_ratio         <= ratio; // [RULE12]
            xref_to_digital_on       <= enable_reg[`PCR_EN_XREF_DIG]; // [RULE20]
            div_ref_to_digital_on    <= enable_reg[`PCR_EN_DIVREF_DIG]; // [RULE21]
            square_clk_to_digital_on <= enable_reg[`PCR_EN_SQR_DIG]; // [RULE21]
            sine_clk_to_digital_on   <= enable_reg[`PCR_EN_SIN_DIG]; // [RULE21]
            square_ref_buffer_on     <= enable_reg[`PCR_EN_SQ_BUF] & ~sin_sel; // [RULE9]
            sine_ref_buffer_on       <= enable_reg[`PCR_EN_SIN_BUF] & sin_sel; // [RULE10]
            mod_clk_from_osc         <= enable_reg[`PCR_EN_OSC_DIG]; // [RULE3]
            lock_logic_on            <= enable_reg[`PCR_EN_LKD_LOGIC] & bias; // [RULE8]
            pump_output_on           <= enable_reg[`PCR_EN_PUMP] & bias; // [RULE4]
            modulator_run            <= enable_reg[`PCR_EN_MOD_RUN] & bias; // [RULE5]
            lock_detect_run          <= enable_reg[`PCR_EN_LKD_RUN] & bias; // [RULE6]
            slip_prevention_on       <= enable_reg[`PCR_EN_SLIP] & slip_arm & bias; // [RULE7]
            prescaler_long_low       <= prescaler_reg; // [RULE15]
            pd_invert                <= pd_ctrl_reg[`PCR_PD_INVERT]; // [RULE16]
            pump_up                  <= up_next & pd_ctrl_reg[`PCR_PD_UP_PASS] & bias; // [RULE17]
            pump_dn                  <= dn_next & pd_ctrl_reg[`PCR_PD_DN_PASS] & bias; // [RULE17]
            lock_detect_out          <= pd_lock_raw & enable_reg[`PCR_EN_LKD_LOGIC] &
                                        enable_reg[`PCR_EN_LKD_RUN] & bias; // [RULE8]
            pd_delay                 <= pd_delay_reg; // [RULE18]
            pump_up_current          <= pump_cur_reg[`PCR_CUR_UP_HI:0]; // [RULE19]
            pump_down_current        <= pump_cur_reg[`PCR_CUR_DN_HI:`PCR_CUR_DN_LO]; // [RULE19]
        end
    end
endmodule // pcr_top

// ==== pcr_checker_assertions.sv ====
// assertion checker for the register bank ports
`timescale 1ns/10ps
module pcr_checker (
    input logic       core_clk,
    input logic       arst_n,
    input logic       serial_select,
    input logic       slip_arm,
    input logic       pd_up_raw,
    input logic       pd_dn_raw,
    input logic       pd_lock_raw,
    input logic       lock_or_readback_pin_oe,
    input logic       loop_bias_on,
    input logic       ref_divider_run,
    input logic       square_ref_buffer_on,
    input logic       sine_ref_buffer_on,
    input logic       lock_logic_on,
    input logic       pump_output_on,
    input logic       modulator_run,
    input logic       lock_detect_run,
    input logic       slip_prevention_on,
    input logic       pd_invert,
    input logic       pump_up,
    input logic       pump_dn,
    input logic       lock_detect_out,
    input logic [2:0] pd_delay,
    input logic [4:0] pump_up_current,
    input logic [4:0] pump_down_current
);
    logic [3:0] up_cnt_reg;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // cycles since reset release, saturating
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            up_cnt_reg <= 4'h0;
        else if (up_cnt_reg != 4'hf)
            up_cnt_reg <= up_cnt_reg + 4'h1;
    end
    a_up_path: assert property (pump_up |-> loop_bias_on && (pd_invert ? $past(pd_dn_raw) : $past(pd_up_raw)))
        else $error("pump up without its cause");
    a_dn_path: assert property (pump_dn |-> loop_bias_on && (pd_invert ? $past(pd_up_raw) : $past(pd_dn_raw)))
        else $error("pump down without its cause");
    a_lock_gate: assert property (lock_detect_out |-> lock_logic_on && lock_detect_run && $past(pd_lock_raw))
        else $error("lock out not gated");
    a_slip_gate: assert property (slip_prevention_on |-> loop_bias_on && $past(slip_arm))
        else $error("slip prevention without arm");
    a_bias_off: assert property (!loop_bias_on |-> !(ref_divider_run || pump_output_on || modulator_run ||
        lock_detect_run || lock_logic_on || slip_prevention_on))
        else $error("loop active without bias");
    a_buf_excl: assert property (!(square_ref_buffer_on && sine_ref_buffer_on))
        else $error("both reference buffers on");
    a_reset_defaults: assert property ($rose(arst_n) |-> ##[1:6] (pd_delay == 3'h2 &&
        pump_up_current == 5'h10 && pump_down_current == 5'h10 && lock_or_readback_pin_oe && loop_bias_on))
        else $error("defaults missing after reset");
    a_idle_hold: assert property ((!serial_select)[*6] ##0 (up_cnt_reg == 4'hf) |-> $stable(pd_delay) &&
        $stable(pump_up_current) && $stable(pump_down_current))
        else $error("settings changed outside a frame");
    c_pump_up: cover property (pump_up);
    c_slip_on: cover property (slip_prevention_on);
    c_lock_out: cover property (lock_detect_out);
    c_pin_release: cover property ($fell(lock_or_readback_pin_oe));
endmodule // pcr_checker

bind pcr_top pcr_checker pcr_checker_inst (
    .core_clk, .arst_n, .serial_select, .slip_arm, .pd_up_raw, .pd_dn_raw, .pd_lock_raw,
    .lock_or_readback_pin_oe, .loop_bias_on, .ref_divider_run, .square_ref_buffer_on, .sine_ref_buffer_on,
    .lock_logic_on, .pump_output_on, .modulator_run, .lock_detect_run, .slip_prevention_on, .pd_invert,
    .pump_up, .pump_dn, .lock_detect_out, .pd_delay, .pump_up_current, .pump_down_current
);

// ==== pcr_host_model.sv ====
// host controller model for the four-wire serial port
`timescale 1ns/10ps
module pcr_host_model (
    input  logic core_clk,
    output logic sclk,
    output logic serial_select,
    output logic serial_in,
    input  logic pin_out,
    input  logic pin_oe
);
    wire pin_lvl = pin_oe ? pin_out : 1'b1;
    initial begin
        sclk = 1'b0;
        serial_select = 1'b0;
        serial_in = 1'b0;
    end
    // one frame; nrise below 32 aborts it
    task automatic xfer(input logic rd, input logic [5:0] adr, input logic [23:0] wd,
                        input int nrise, output logic [23:0] q);
        logic [31:0] w;
        w = {rd, adr, wd, 1'b0};
        q = 24'h0;
        @(posedge core_clk);
        serial_select <= 1'b1;
        for (int i = 0; i < nrise; i++) begin
            serial_in <= w[31-i];
            repeat (3) @(posedge core_clk);
            sclk <= 1'b1;
            repeat (6) @(posedge core_clk);
            if (i >= 7 && i <= 30)
                q[30-i] = pin_lvl;
            sclk <= 1'b0;
        end
        serial_select <= 1'b0;
        serial_in <= ~serial_in;
        repeat (3) @(posedge core_clk);
    endtask
endmodule // pcr_host_model

// ==== tb_top.sv ====
// self-checking testbench for the register bank
`timescale 1ns/10ps
module tb_top;
    logic        core_clk, arst_n, sclk, serial_select, serial_in;
    logic        slip_arm, pd_up_raw, pd_dn_raw, pd_lock_raw;
    logic        lock_or_readback_pin_out, lock_or_readback_pin_oe;
    logic        osc_buffer_on, loop_bias_on, ref_divider_run, ref_divider_used;
    logic [13:0] ref_divide_ratio;
    logic        xref_to_digital_on, div_ref_to_digital_on, square_clk_to_digital_on, sine_clk_to_digital_on;
    logic        square_ref_buffer_on, sine_ref_buffer_on, mod_clk_from_osc, prescaler_bias_on;
    logic        lock_logic_on, pump_output_on, modulator_run, lock_detect_run, slip_prevention_on;
    logic        prescaler_long_low, pd_invert, pump_up, pump_dn, lock_detect_out;
    logic [2:0]  pd_delay;
    logic [4:0]  pump_up_current, pump_down_current;
    logic [23:0] m [1:7];
    logic [23:0] q;
    logic [23:0] d;
    logic [16:0] rtab [6] = '{17'h08001, 17'h08005, 17'h04001, 17'h00005, 17'h1c001, 17'h10002};
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;
    wire  [48:0] obs = {osc_buffer_on, loop_bias_on, ref_divider_run, ref_divider_used, ref_divide_ratio,
        xref_to_digital_on, div_ref_to_digital_on, square_clk_to_digital_on, sine_clk_to_digital_on,
        square_ref_buffer_on, sine_ref_buffer_on, mod_clk_from_osc, prescaler_bias_on, lock_logic_on,
        pump_output_on, modulator_run, lock_detect_run, slip_prevention_on, prescaler_long_low, pd_invert,
        pump_up, pump_dn, lock_detect_out, pd_delay, pump_up_current, pump_down_current};

    pcr_top pcr_top_inst (.*);
    pcr_host_model pcr_host_model_inst (.core_clk(core_clk), .sclk(sclk), .serial_select(serial_select),
        .serial_in(serial_in), .pin_out(lock_or_readback_pin_out), .pin_oe(lock_or_readback_pin_oe));

    always #2.5 core_clk = ~core_clk;

    function automatic logic [23:0] msk(input int a);
        case (a)
            1: return 24'h00ffff;
            2: return 24'h000003;
            3: return 24'h01ffff;
            4: return 24'h000001;
            5, 6: return 24'h000007;
            7: return 24'h0003ff;
            default: return 24'h000000;
        endcase
    endfunction

    function automatic logic [48:0] exp_o();
        logic [15:0] e;
        logic [16:0] r;
        logic        b;
        logic        iv;
        e = m[1][15:0];
        r = m[3][16:0];
        b = e[1];
        iv = m[5][0];
        return {e[0], b, e[2] & b, e[2] & (r[15] ? r[13:0] != 14'h1 : r[14]), r[13:0],
            e[3], e[4], e[5], e[6], e[7] & ~r[16], e[8] & r[16], e[9], e[10] & b, e[11] & b,
            e[12] & b, e[13] & b, e[14] & b, e[15] & slip_arm & b, m[4][0], iv,
            (iv ? pd_dn_raw : pd_up_raw) & m[5][1] & b, (iv ? pd_up_raw : pd_dn_raw) & m[5][2] & b,
            pd_lock_raw & e[11] & e[14] & b, m[6][2:0], m[7][4:0], m[7][9:5]};
    endfunction

    task automatic chk(input string what, input logic [48:0] got, input logic [48:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic defaults();
        m = '{24'h00fe9b, 24'h000003, 24'h008001, 24'h000000, 24'h000006, 24'h000002, 24'h000210};
    endtask

    task automatic settle(input string what);
        @(posedge core_clk);
        {slip_arm, pd_up_raw, pd_dn_raw, pd_lock_raw} <= 4'($urandom);
        repeat (3) @(posedge core_clk);
        #1;
        chk(what, obs, exp_o());
    endtask

    task automatic wr(input logic [5:0] a, input logic [23:0] v);
        pcr_host_model_inst.xfer(1'b0, a, v, 32, q);
        if (a >= 6'h01 && a <= 6'h07)
            m[a] = v & msk(a);
        settle("outputs");
    endtask

    task automatic rd(input logic [5:0] a, input logic [23:0] e);
        pcr_host_model_inst.xfer(1'b1, a, 24'h0, 32, q);
        chk("readback", {25'h0, q}, {25'h0, e});
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            $display("[ERR] run length expected under 30000 cycles seen %0d", cyc);
            close_out();
        end
    end

    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        {slip_arm, pd_up_raw, pd_dn_raw, pd_lock_raw} = 4'h0;
        void'($urandom(32'h3981));
        defaults();
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        settle("reset values");
        rd(6'h03, 24'hffffff);
        wr(6'h02, 24'h000002);
        chk("pin forced", {47'h0, lock_or_readback_pin_out, lock_or_readback_pin_oe}, 49'h1);
        wr(6'h02, 24'h000000);
        chk("pin idle", {48'h0, lock_or_readback_pin_oe}, 49'h0);
        $display("test pin force done");
        for (int k = 0; k < 3; k++) begin
            for (int a = 1; a <= 7; a++) begin
                d = (k == 0) ? 24'hffffff : 24'($urandom);
                if (d[13:0] == 14'h0)
                    d[0] = 1'b1;
                if (a != 2)
                    wr(6'(a), d);
            end
            for (int a = 1; a <= 7; a++)
                rd(6'(a), m[a]);
        end
        $display("test random registers done");
        wr(6'h01, 24'h00ffff);
        foreach (rtab[i])
            wr(6'h03, {7'h0, rtab[i]});
        $display("test reference path done");
        wr(6'h08, 24'h5a5a5a);
        rd(6'h08, 24'h000000);
        pcr_host_model_inst.xfer(1'b0, 6'h06, 24'h000005, 20, q);
        settle("after abort");
        $display("test unmapped and abort done");
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        defaults();
        repeat (8) @(posedge core_clk);
        settle("second reset");
        $display("test second reset done");
        close_out();
    end
endmodule // tb_top
